// [logic/sdcci_core.sv]
// Contract
// [R1] Inputs sampled at rising true clock crossing
// [R2] Read data changes on both crossings
// [R3] Clock enable low freezes outputs, burst
// [R4] Clock enable low enters power modes
// [R5] Bank bits select one of eight banks
// [R6] Controller gives row and column addresses
// [R7] Mode register set loads address op-code
// [R8] Controller keeps the refresh rate
// [R9] Additive latency zero, CL-1 or CL-2
// [R10] Burst length four or eight beats
// [R11] Sequential or interleaved burst ordering
// [R12] Eight banks held open concurrently
// [R13] Data travels with the data strobe
// [R14] Address bit ten: auto or all-bank precharge
// [R15] Address bit twelve low chops the burst
// [R16] Strobe levels decode the command
// [R17] Chip select high masks commands
// [R18] Controller opens row before access
// [R19] Controller keeps row and precharge delays
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "sdcci_map.svh"

module sdcci_core (
    input  wire logic        pclk,                    // System clock
    input  wire logic        presetn,                 // Async reset, active low
    input  wire logic [7:0]  paddr,                   // APB byte address
    input  wire logic        psel,                    // APB select
    input  wire logic        penable,                 // APB access phase
    input  wire logic        pwrite,                  // APB direction
    input  wire logic [31:0] pwdata,                  // APB write data
    output logic      [31:0] prdata,                  // APB read data
    output logic             pready,                  // APB ready
    output logic             pslverr,                 // APB error
    input  wire logic        true_clock,              // Link clock, true
    input  wire logic        complement_clock,        // Link clock, complement
    input  wire logic        clock_enable,            // Clock enable pin
    input  wire logic        chip_select_n,           // Chip select, low active
    input  wire logic        row_strobe_n,            // Row strobe, low active
    input  wire logic        column_strobe_n,         // Column strobe, low active
    input  wire logic        write_enable_n,          // Write enable, low active
    input  wire logic [2:0]  bank_select_bits,        // Bank select
    input  wire logic [12:0] row_column_address_bits, // Address and op-code
    input  wire logic [15:0] dq_in,                   // Data pins, input side
    output logic      [15:0] dq_out,                  // Data pins, output side
    output logic             dq_oe,                   // Data pins drive enable
    input  wire logic        dqs_in,                  // Strobe, input side
    output logic             dqs_out,                 // Strobe true, output
    output logic             dqs_n_out,               // Strobe complement, output
    output logic             dqs_oe                   // Strobe drive enable
);

    // Pin synchroniser and edge history
    logic [`SDCCI_SYNC_W-1:0] sync1;
    logic [`SDCCI_SYNC_W-1:0] sync2;
    logic [`SDCCI_SYNC_W-1:0] hist;

    // Power state, current and next
    sdcci_pkg::sdcci_pwr_e pwr;
    sdcci_pkg::sdcci_pwr_e next_pwr;

    // Mode registers and control
    logic [12:0] mode0;
    logic [12:0] mode1;
    logic        dec_en;
    logic [15:0] cmd_cnt;
    logic [15:0] wdata;

    // Bank state
    logic [7:0]  bank_open;
    logic [12:0] bank_row [8];

    // Burst engine
    logic        pend;
    logic        active;
    logic        is_read;
    logic        bl4;
    logic        btype;
    logic        ap;
    logic [2:0]  bbank;
    logic [9:0]  bcol;
    logic [4:0]  lat;
    logic [3:0]  beat;
    logic [3:0]  beats;
    logic        burst_done;

    // Input vector gathered from the pins
    wire [`SDCCI_SYNC_W-1:0] pins = {true_clock, complement_clock, clock_enable,
                                     chip_select_n, row_strobe_n, column_strobe_n,
                                     write_enable_n, bank_select_bits,
                                     row_column_address_bits, dqs_in, dq_in};

    // Two flip-flops before any logic, plus one stage of history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= '0;
            sync2 <= '0;
            hist  <= '0;
        end else begin
            sync1 <= pins;
            sync2 <= sync1;
            hist  <= sync2;
        end
    end

    // Named views of the synchronised pins
    wire        s_tck  = sync2[`SDCCI_SX_TCK];
    wire        s_cck  = sync2[`SDCCI_SX_CCK];
    wire        h_tck  = hist[`SDCCI_SX_TCK];
    wire        h_cck  = hist[`SDCCI_SX_CCK];
    wire        s_cke  = sync2[`SDCCI_SX_CKE];
    wire        s_cs   = sync2[`SDCCI_SX_CS];
    wire        s_ras  = sync2[`SDCCI_SX_RAS];
    wire        s_cas  = sync2[`SDCCI_SX_CAS];
    wire        s_we   = sync2[`SDCCI_SX_WE];
    wire [2:0]  s_ba   = sync2[`SDCCI_SX_BA_MSB:`SDCCI_SX_BA_LSB];
    wire [12:0] s_a    = sync2[`SDCCI_SX_A_MSB:`SDCCI_SX_A_LSB];
    wire        s_dqs  = sync2[`SDCCI_SX_DQS];
    wire        h_dqs  = hist[`SDCCI_SX_DQS];
    wire [15:0] s_dq   = sync2[`SDCCI_SX_DQ_MSB:`SDCCI_SX_DQ_LSB];

    // Crossing detection on the differential pair
    // [R1] rising crossing samples
    wire rise_x = s_tck & ~s_cck & ~(h_tck & ~h_cck);
    // [R2] falling crossing too
    wire fall_x = ~s_tck & s_cck & ~(~h_tck & h_cck);
    // [R3] ticks only while running
    wire run    = (pwr == sdcci_pkg::SDCCI_RUN);
    wire tick   = rise_x & run;
    wire ftick  = fall_x & run;

    // Command decode
    // [R17] chip select gates decoder
    wire cmd_ok  = tick & s_cke & ~s_cs & dec_en;
    // [R16] strobe level decode
    wire c_act   = cmd_ok & ~s_ras &  s_cas &  s_we;
    wire c_pre   = cmd_ok & ~s_ras &  s_cas & ~s_we;
    wire c_rd    = cmd_ok &  s_ras & ~s_cas &  s_we;
    wire c_wr    = cmd_ok &  s_ras & ~s_cas & ~s_we;
    wire c_mrs   = cmd_ok & ~s_ras & ~s_cas & ~s_we;
    wire c_ref   = tick & ~s_cs & dec_en & ~s_ras & ~s_cas & s_we;
    wire any_cmd = c_act | c_pre | c_rd | c_wr | c_mrs | c_ref;
    // A new access is taken only when no burst is in flight
    wire start   = (c_rd | c_wr) & ~pend & ~active;

    // Clock enable handling and power mode entry/exit
    always_comb begin
        next_pwr = pwr;
        case (pwr)
            sdcci_pkg::SDCCI_RUN: begin
                // [R4] entry on clock enable low
                if (rise_x && !s_cke) begin
                    if (bank_open != 8'h00 || pend || active)
                        next_pwr = sdcci_pkg::SDCCI_SUSP;
                    else if (c_ref)
                        next_pwr = sdcci_pkg::SDCCI_SREF;
                    else
                        next_pwr = sdcci_pkg::SDCCI_PDOWN;
                end
            end
            sdcci_pkg::SDCCI_SUSP,
            sdcci_pkg::SDCCI_PDOWN,
            sdcci_pkg::SDCCI_SREF: begin
                if (rise_x && s_cke)
                    next_pwr = sdcci_pkg::SDCCI_RUN;
            end
            default: next_pwr = sdcci_pkg::SDCCI_RUN;
        endcase
    end

    // Power state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pwr <= sdcci_pkg::SDCCI_RUN;
        else
            pwr <= next_pwr;
    end

    // Mode register load from the address op-code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode0 <= '0;
            mode1 <= '0;
        end else if (c_mrs) begin
            // [R7] op-code from address
            if (s_ba == `SDCCI_MR_SEL0)
                mode0 <= s_a;
            if (s_ba == `SDCCI_MR_SEL1)
                mode1 <= s_a;
        end
    end

    // Latency derived from the mode registers
    wire [1:0] al_f   = mode1[`SDCCI_MR1_AL_MSB:`SDCCI_MR1_AL_LSB];
    wire [4:0] cl     = 5'(mode0[`SDCCI_MR0_CL_MSB:`SDCCI_MR0_CL_LSB]) + `SDCCI_CL_BASE;
    // [R9] additive latency choice
    wire [4:0] al     = (al_f == `SDCCI_AL_CLM1) ? cl - 5'h01 :
                        (al_f == `SDCCI_AL_CLM2) ? cl - 5'h02 : 5'h00;
    wire [4:0] rl     = 5'(al + cl);

    // Burst length per access
    wire [1:0] bl_f   = mode0[`SDCCI_MR0_BL_MSB:`SDCCI_MR0_BL_LSB];
    // [R10] four or eight beats
    // [R15] bit twelve chops burst
    wire       cut4   = (bl_f == `SDCCI_BL_OTF) ? ~s_a[`SDCCI_A_BC] :
                        (bl_f != `SDCCI_BL_FIXED8);

    // Per-bank row state
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_bank
            wire hit      = (s_ba == 3'(gi));
            // [R14] single or all-bank precharge
            wire pre_hit  = c_pre & (s_a[`SDCCI_A_AP] | hit);
            wire auto_hit = burst_done & ap & (bbank == 3'(gi));
            // [R12] independent bank state
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    bank_open[gi] <= 1'b0;
                    bank_row[gi]  <= '0;
                end else if (c_act && hit) begin
                    // [R5] bank bits pick bank
                    bank_open[gi] <= 1'b1;
                    bank_row[gi]  <= s_a;
                end else if (pre_hit || auto_hit) begin
                    bank_open[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // Column of the current beat
    // [R11] sequential or interleaved order
    wire [2:0] lo_seq = bl4 ? {bcol[2], 2'(bcol[1:0] + beat[1:0])} : 3'(bcol[2:0] + beat[2:0]);
    wire [2:0] lo_col = btype ? (bcol[2:0] ^ beat[2:0]) : lo_seq;
    wire [9:0] cur_col = {bcol[9:3], lo_col};
    // Read beats advance on every crossing, write beats on strobe edges
    wire rd_edge  = active & is_read & (tick | ftick);
    // [R13] capture on strobe edges
    wire wr_edge  = active & ~is_read & run & (s_dqs ^ h_dqs);
    wire last     = (beat == beats - 4'h1);
    assign burst_done = (rd_edge | wr_edge) & last;

    // Burst sequencing; frozen while the internal clock is suspended
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend    <= 1'b0;
            active  <= 1'b0;
            is_read <= 1'b0;
            bl4     <= 1'b0;
            btype   <= 1'b0;
            ap      <= 1'b0;
            bbank   <= '0;
            bcol    <= '0;
            lat     <= '0;
            beat    <= '0;
            beats   <= '0;
        end else if (start) begin
            // [R6] column from low bits
            pend    <= 1'b1;
            is_read <= c_rd;
            bl4     <= cut4;
            btype   <= mode0[`SDCCI_MR0_BT];
            ap      <= s_a[`SDCCI_A_AP];
            bbank   <= s_ba;
            bcol    <= s_a[9:0];
            lat     <= rl;
            beat    <= '0;
            beats   <= cut4 ? `SDCCI_BEATS4 : `SDCCI_BEATS8;
        end else if (pend && tick) begin
            // [R3] latency counts only on ticks
            if (lat <= 5'h01) begin
                pend   <= 1'b0;
                active <= 1'b1;
            end else begin
                lat <= lat - 5'h01;
            end
        end else if (burst_done) begin
            active <= 1'b0;
            beat   <= '0;
        end else if (rd_edge || wr_edge) begin
            beat <= beat + 4'h1;
        end
    end

    // Read data and strobe drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dq_out    <= '0;
            dq_oe     <= 1'b0;
            dqs_out   <= 1'b0;
            dqs_n_out <= 1'b1;
            dqs_oe    <= 1'b0;
        end else if (rd_edge && !last) begin
            // [R2] one beat per crossing
            dq_out    <= {bbank, cur_col, beat[2:0]};
            dq_oe     <= 1'b1;
            // [R13] strobe follows data
            dqs_out   <= ~dqs_out;
            dqs_n_out <= dqs_out;
            dqs_oe    <= 1'b1;
        end else if (rd_edge) begin
            dq_out    <= {bbank, cur_col, beat[2:0]};
            dqs_out   <= ~dqs_out;
            dqs_n_out <= dqs_out;
        end else if (!active) begin
            dq_oe     <= 1'b0;
            dqs_oe    <= 1'b0;
            dqs_out   <= 1'b0;
            dqs_n_out <= 1'b1;
        end
    end

    // Write capture and command counting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdata   <= '0;
            cmd_cnt <= '0;
        end else begin
            if (wr_edge)
                wdata <= s_dq;
            if (any_cmd)
                cmd_cnt <= cmd_cnt + 16'h0001;
        end
    end

    // APB decode
    wire acc     = psel & penable & ~pready;
    wire hit_ct  = (paddr == `SDCCI_OFF_CTRL);
    wire hit_st  = (paddr == `SDCCI_OFF_STATUS);
    wire hit_m0  = (paddr == `SDCCI_OFF_MODE0);
    wire hit_m1  = (paddr == `SDCCI_OFF_MODE1);
    wire hit_wd  = (paddr == `SDCCI_OFF_WDATA);
    wire hit_cc  = (paddr == `SDCCI_OFF_CMDCNT);
    wire mapped  = hit_ct | hit_st | hit_m0 | hit_m1 | hit_wd | hit_cc;
    wire [31:0] status = ({24'h0, bank_open} << `SDCCI_ST_BANKS_LSB)
                       | ({28'h0, pwr} << `SDCCI_ST_PWR_LSB)
                       | ({31'h0, pend | active} << `SDCCI_ST_BUSY);
    wire [31:0] rsel = hit_ct ? {31'h0, dec_en} :
                       hit_st ? status :
                       hit_m0 ? {19'h0, mode0} :
                       hit_m1 ? {19'h0, mode1} :
                       hit_wd ? {16'h0, wdata} :
                       hit_cc ? {16'h0, cmd_cnt} : 32'h0;

    // APB answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= acc;
            pslverr <= acc & ~mapped;
            prdata  <= (acc && !pwrite) ? rsel : 32'h0;
        end
    end

    // Control register write at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            dec_en <= `SDCCI_CTRL_RST;
        else if (psel && penable && pready && pwrite && hit_ct)
            dec_en <= pwdata[`SDCCI_CTRL_DEC_EN];
    end

endmodule // sdcci_core

// [include/sdcci_map.svh]
`ifndef SDCCI_MAP_SVH
`define SDCCI_MAP_SVH

// APB register byte offsets
`define SDCCI_OFF_CTRL     8'h00
`define SDCCI_OFF_STATUS   8'h04
`define SDCCI_OFF_MODE0    8'h08
`define SDCCI_OFF_MODE1    8'h0c
`define SDCCI_OFF_WDATA    8'h10
`define SDCCI_OFF_CMDCNT   8'h14

// Control register fields and reset value
`define SDCCI_CTRL_DEC_EN  0
`define SDCCI_CTRL_RST     1'h1

// Status register field positions
`define SDCCI_ST_BANKS_LSB 0
`define SDCCI_ST_PWR_LSB   8
`define SDCCI_ST_BUSY      12

// Mode register selection on the bank bits
`define SDCCI_MR_SEL0      3'h0
`define SDCCI_MR_SEL1      3'h1

// Mode register 0 fields
`define SDCCI_MR0_BL_MSB   1
`define SDCCI_MR0_BL_LSB   0
`define SDCCI_MR0_BT       3
`define SDCCI_MR0_CL_MSB   6
`define SDCCI_MR0_CL_LSB   4
`define SDCCI_BL_FIXED8    2'h0
`define SDCCI_BL_OTF       2'h1

// Mode register 1 fields
`define SDCCI_MR1_AL_MSB   4
`define SDCCI_MR1_AL_LSB   3
`define SDCCI_AL_CLM1      2'h1
`define SDCCI_AL_CLM2      2'h2

// Latency base added to the column latency field
`define SDCCI_CL_BASE      5'h05

// Special address bits
`define SDCCI_A_AP         10
`define SDCCI_A_BC         12

// Burst lengths in beats
`define SDCCI_BEATS8       4'h8
`define SDCCI_BEATS4       4'h4

// Bit positions in the synchronised pin vector
`define SDCCI_SYNC_W       40
`define SDCCI_SX_TCK       39
`define SDCCI_SX_CCK       38
`define SDCCI_SX_CKE       37
`define SDCCI_SX_CS        36
`define SDCCI_SX_RAS       35
`define SDCCI_SX_CAS       34
`define SDCCI_SX_WE        33
`define SDCCI_SX_BA_MSB    32
`define SDCCI_SX_BA_LSB    30
`define SDCCI_SX_A_MSB     29
`define SDCCI_SX_A_LSB     17
`define SDCCI_SX_DQS       16
`define SDCCI_SX_DQ_MSB    15
`define SDCCI_SX_DQ_LSB    0

`endif

// [include/sdcci_pkg.sv]
package sdcci_pkg;
    // Power and clock state, one-hot
    typedef enum logic [3:0] {
        SDCCI_RUN   = 4'h1,
        SDCCI_SUSP  = 4'h2,
        SDCCI_PDOWN = 4'h4,
        SDCCI_SREF  = 4'h8
    } sdcci_pwr_e;
endpackage

// [bench/sdcci_core_properties.sv]
`timescale 1ns/1ps

module sdcci_core_properties (
    input wire logic        pclk,         // System clock
    input wire logic        presetn,      // Async reset, active low
    input wire logic        clock_enable, // Clock enable pin
    input wire logic [15:0] dq_out,       // Read data
    input wire logic        dq_oe,        // Read data enable
    input wire logic        dqs_out,      // Strobe true
    input wire logic        dqs_n_out,    // Strobe complement
    input wire logic        dqs_oe        // Strobe enable
);
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [4:0] cke_low; // Cycles with clock enable low
    logic [3:0] beats;   // Beats seen in this burst
    logic       oe_q;    // Strobe enable, last cycle
    logic       dqs_q;   // Strobe level, last cycle

    // Suspend span and beat counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cke_low <= 5'h00;
            beats   <= 4'h0;
            oe_q    <= 1'b0;
            dqs_q   <= 1'b0;
        end else begin
            cke_low <= clock_enable ? 5'h00 : cke_low + {4'h0, cke_low != 5'h1f};
            beats   <= !dqs_oe ? 4'h0 : beats + {3'h0, !oe_q || dqs_out != dqs_q};
            oe_q    <= dqs_oe;
            dqs_q   <= dqs_out;
        end
    end

    strobe_pair_a:
    assert property (dqs_oe |-> dqs_n_out != dqs_out) else $error("Strobe pair not complementary");
    data_strobe_a:
    assert property (dq_oe == dqs_oe) else $error("Data driven without its strobe");
    strobe_idle_a:
    assert property (!dqs_oe |-> !dqs_out && dqs_n_out) else $error("Idle strobe not parked");
    first_beat_a:
    assert property ($rose(dqs_oe) |-> dqs_out) else $error("First beat strobe not high");
    beat_on_edge_a:
    assert property (dq_oe && $past(dq_oe) && $changed(dq_out) |-> $changed(dqs_out))
        else $error("Data moved without a strobe edge");
    edge_spacing_a:
    assert property (dqs_oe && $changed(dqs_out) |=> ($stable(dqs_out) || !dqs_oe) [*3])
        else $error("Strobe edges closer than a half period");
    burst_length_a:
    assert property ($fell(dqs_oe) |-> beats == 4'h4 || beats == 4'h8)
        else $error("Burst neither four nor eight beats");
    suspend_freeze_a:
    assert property (cke_low >= 5'h10 |-> $stable(dq_out) && $stable(dqs_out) && $stable(dq_oe))
        else $error("Outputs moved while clock suspended");
endmodule // sdcci_core_properties

bind sdcci_core sdcci_core_properties chk (.pclk, .presetn, .clock_enable, .dq_out, .dq_oe,
    .dqs_out, .dqs_n_out, .dqs_oe);

// [bench/sdcci_ctl_model.sv]
`timescale 1ns/1ps

module sdcci_ctl_model (
    output logic        true_clock,              // Link clock, true
    output logic        complement_clock,        // Link clock, complement
    output logic        clock_enable,            // Clock enable
    output logic        chip_select_n,           // Chip select
    output logic        row_strobe_n,            // Row strobe
    output logic        column_strobe_n,         // Column strobe
    output logic        write_enable_n,          // Write enable
    output logic [2:0]  bank_select_bits,        // Bank select
    output logic [12:0] row_column_address_bits, // Address or op-code
    output logic [15:0] dq_in,                   // Write data
    output logic        dqs_in                   // Write strobe
);
    // Idle pins, then a free-running pair offset from pclk
    initial begin
        clock_enable = 1'b1;
        {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'hf;
        bank_select_bits = 3'h0;
        row_column_address_bits = 13'h0000;
        dq_in = 16'h0000;
        dqs_in = 1'b0;
        true_clock = 1'b0;
        complement_clock = 1'b1;
        #37;
        forever begin
            #200;
            true_clock = ~true_clock;
            complement_clock = ~complement_clock;
        end
    end

    // held a whole period around the crossing
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
                       input logic e);
        @(negedge true_clock);
        {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = c;
        bank_select_bits = b;
        row_column_address_bits = a;
        clock_enable = e;
        @(negedge true_clock);
        {chip_select_n, row_strobe_n, column_strobe_n, write_enable_n} = 4'h7;
        bank_select_bits = ~b;
        row_column_address_bits = ~a;
    endtask

    // data set half a beat before each strobe edge
    task automatic wburst(input int n, input logic [15:0] base, input int rl);
        repeat (rl) @(posedge true_clock);
        for (int k = 0; k < n; k++) begin
            @(true_clock);
            dq_in = base + 16'(k);
            #100;
            dqs_in = ~dqs_in;
        end
        #100;
        dq_in = ~dq_in;
    endtask
endmodule // sdcci_ctl_model

// [bench/testbench.sv]
`timescale 1ns/1ps
`include "sdcci_map.svh"

`define CHK(nm, x, y) begin samples_checked++; if ((y) !== (x)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, x, y); end end

module testbench;
    localparam logic [3:0] MRS = 4'h0, REF = 4'h1, PRE = 4'h2, ACT = 4'h3;
    localparam logic [3:0] WR = 4'h4, RD = 4'h5, NOP = 4'h7;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, v;
    logic        pready, pslverr, true_clock, complement_clock, clock_enable, e;
    logic        chip_select_n, row_strobe_n, column_strobe_n, write_enable_n, dqs_in;
    logic [2:0]  bank_select_bits;
    logic [12:0] row_column_address_bits;
    logic [15:0] dq_in, dq_out;
    logic        dq_oe, dqs_out, dqs_n_out, dqs_oe;
    logic [12:0] op0 [3] = '{13'h000, 13'h011, 13'h028};
    int          rl [3] = '{5, 11, 12};
    int          bad_count = 0, samples_checked = 0;

    sdcci_core uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .true_clock, .complement_clock, .clock_enable, .chip_select_n,
        .row_strobe_n, .column_strobe_n, .write_enable_n, .bank_select_bits,
        .row_column_address_bits, .dq_in, .dq_out, .dq_oe, .dqs_in, .dqs_out, .dqs_n_out,
        .dqs_oe);

    sdcci_ctl_model ctl (.true_clock, .complement_clock, .clock_enable, .chip_select_n,
        .row_strobe_n, .column_strobe_n, .write_enable_n, .bank_select_bits,
        .row_column_address_bits, .dq_in, .dqs_in);

    // System clock
    initial begin
        forever #25 pclk = ~pclk;
    end

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic f);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) bad_count++;
        q = prdata;
        f = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic expect_reg(input string nm, input logic [7:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic        f;
        apb(1'b0, a, 32'h0, q, f);
        `CHK(nm, x, q)
    endtask

    task automatic expect_st(input string nm, input logic [3:0] p, input logic [7:0] b);
        expect_reg(nm, `SDCCI_OFF_STATUS, {20'h0, p, b});
    endtask

    // Bank 3, column 0x1f5 pattern per beat
    function automatic logic [15:0] beat(input int i, input int k);
        logic [2:0] lo;
        lo = (i == 0) ? 3'(5 + k) : (i == 1) ? {1'b1, 2'(1 + k)} : 3'(5 ^ k);
        return {3'h3, 7'h3e, lo, 3'(k)};
    endfunction

    // Capture a read burst, timing in link falling edges
    task automatic read_burst(input int i);
        int   lat = 0;
        int   k = 0;
        logic pv = 1'b0;
        logic ds = 1'b0;
        for (int t = 0; t < 400 && (k == 0 || dq_oe === 1'b1); t++) begin
            @(negedge pclk);
            if (pv && !true_clock && k == 0) lat++;
            pv = true_clock;
            if (dq_oe === 1'b1 && (k == 0 || dqs_out !== ds)) begin
                if (k == 0) `CHK("latency", rl[i], lat)
                `CHK("beat", beat(i, k), dq_out)
                k++;
            end
            ds = dqs_out;
        end
        `CHK("beats", (i == 1) ? 4 : 8, k)
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        expect_reg("ctrl", `SDCCI_OFF_CTRL, 32'h0000_0001);
        expect_st("reset", sdcci_pkg::SDCCI_RUN, 8'h00);
        apb(1'b0, 8'h18, 32'h0, v, e);
        `CHK("slverr", 1'b1, e)
        // Each mode: open row before reading it
        for (int i = 0; i < 3; i++) begin
            ctl.cmd(MRS, 3'h0, op0[i], 1'b1);
            ctl.cmd(MRS, 3'h1, 13'(i << 3), 1'b1);
            expect_reg("mode0", `SDCCI_OFF_MODE0, {19'h0, op0[i]});
            expect_reg("mode1", `SDCCI_OFF_MODE1, 32'(i << 3));
            ctl.cmd(ACT, 3'h3, 13'h1abc, 1'b1);
            expect_st("open", sdcci_pkg::SDCCI_RUN, 8'h08);
            ctl.cmd(RD, 3'h3, {i != 1, 1'b0, i == 2, 10'h1f5}, 1'b1);
            read_burst(i);
            if (i < 2) ctl.cmd(PRE, 3'h3, 13'h0000, 1'b1);
            // Banks idle: one refresh per pass keeps the average rate
            ctl.cmd(REF, 3'h0, 13'h0000, 1'b1);
        end
        expect_st("autopre", sdcci_pkg::SDCCI_RUN, 8'h00);
        // Concurrent banks; masked and disabled commands
        ctl.cmd(ACT, 3'h5, 13'h0123, 1'b1);
        ctl.cmd(ACT, 3'h0, 13'h0456, 1'b1);
        ctl.cmd(4'hb, 3'h1, 13'h0000, 1'b1);
        apb(1'b1, `SDCCI_OFF_CTRL, 32'h0, v, e);
        ctl.cmd(ACT, 3'h2, 13'h0000, 1'b1);
        apb(1'b1, `SDCCI_OFF_CTRL, 32'h1, v, e);
        expect_st("banks", sdcci_pkg::SDCCI_RUN, 8'h21);
        // Write burst on strobe edges
        ctl.cmd(WR, 3'h5, 13'h1000, 1'b1);
        ctl.wburst(8, 16'ha5c0, 12);
        expect_reg("wdata", `SDCCI_OFF_WDATA, 32'h0000_a5c7);
        expect_st("wdone", sdcci_pkg::SDCCI_RUN, 8'h21);
        // Suspend, power-down and self-refresh entry
        ctl.cmd(PRE, 3'h5, 13'h0000, 1'b1);
        ctl.cmd(NOP, 3'h0, 13'h0000, 1'b0);
        expect_st("suspend", sdcci_pkg::SDCCI_SUSP, 8'h01);
        ctl.cmd(NOP, 3'h0, 13'h0000, 1'b1);
        ctl.cmd(PRE, 3'h7, 13'h0400, 1'b1);
        expect_st("preall", sdcci_pkg::SDCCI_RUN, 8'h00);
        ctl.cmd(NOP, 3'h0, 13'h0000, 1'b0);
        expect_st("pdown", sdcci_pkg::SDCCI_PDOWN, 8'h00);
        ctl.cmd(NOP, 3'h0, 13'h0000, 1'b1);
        ctl.cmd(REF, 3'h0, 13'h0000, 1'b0);
        expect_st("sref", sdcci_pkg::SDCCI_SREF, 8'h00);
        ctl.cmd(NOP, 3'h0, 13'h0000, 1'b1);
        expect_st("wake", sdcci_pkg::SDCCI_RUN, 8'h00);
        // Masked and disabled commands leave the count alone
        expect_reg("cmdcnt", `SDCCI_OFF_CMDCNT, 32'h0000_0017);
        wrap_up();
    end

    // Cut a hung run short
    initial begin
        #400000;
        bad_count++;
        wrap_up();
    end
endmodule // testbench
